// ===== hdl/pcs_status.sv
// bus event status word and revision identifier of the host controller
// Operation
// - any detected parity error sets the detected parity error flag (15).
// - each time the block drives the system error pin, flag 14 is set.
// - a target abort received on an own master transaction sets flag 12.
// - ending a transaction as target with target abort sets flag 11.
// - target select timing codes are 00 fast, 01 medium, 10 slow, 11 reserved.
// - bits 10 to 9 report the slowest decode timing, fixed at medium.
// - flag 8 sets only for a parity error pin event as master with enable.
// - bit 7 reads zero, no fast back-to-back to different agents.
// - bit 5 reads zero, the bus runs at 33 MHz only.
// - bit 4 reads one, a capability pointer sits at offset 34H.
// - offset 08H holds a fixed read-only one-byte revision identifier.
// - the status word sits at offset 06H, read only, writes ignored.
// - with parity response off, parity errors are flagged, pin not driven.
// - address parity errors drive the system error pin only if both on.
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_status
  import pcs_pkg::*;
#(
  parameter logic [7:0] REV_ID = `PCS_REVID_DEF  // arbitrary value
)
(
  input  wire logic        clk_i,           // bus clock, 33 MHz
  input  wire logic        rst_i,           // async reset, active high
  // configuration access
  input  wire logic        cfg_rd_i,        // config read strobe
  input  wire logic        cfg_wr_i,        // config write strobe
  input  wire logic [7:2]  cfg_addr_i,      // dword address
  input  wire logic [3:0]  cfg_be_n_i,      // byte enables, active low
  input  wire logic [31:0] cfg_wdata_i,     // write data, unused
  output logic      [31:0] cfg_rdata_o,     // read data
  output logic             cfg_rvalid_o,    // read data valid pulse
  // command word enables
  input  wire logic        parity_response_enable_i, // parity response
  input  wire logic        system_error_enable_i,    // system error drv
  // event inputs from the bus engine
  input  wire logic        addr_parity_err_i,  // address parity error
  input  wire logic        data_parity_err_i,  // data parity error
  input  wire logic        sys_err_req_i,      // other system error
  input  wire logic        master_active_i,    // acting as bus master
  input  wire logic        master_abort_i,     // own cycle master abort
  input  wire logic        special_cycle_i,    // cycle is special cycle
  input  wire logic        target_abort_rcv_i, // target abort received
  input  wire logic        target_abort_sig_i, // target abort signalled
  input  wire logic        decode_timing_i,    // unused spare, tie low
  // parity error pin
  input  wire logic        perr_n_i,        // pin level, active low
  output logic             perr_n_o,        // pin drive value
  output logic             perr_oe_o,       // pin output enable
  // system error pin, open drain
  output logic             serr_n_o,        // pin drive value
  output logic             serr_oe_o        // pin output enable
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] rdata;
    logic        rvalid;
    logic        perr_drive;
    logic        perr_n;
    logic        serr_drive;
    logic        serr_n;
    logic        perr_meta;
    logic        perr_sync;
  } pcs_state_s;

  pcs_state_s  st;
  pcs_state_s  next_st;
  pcs_flags_t  set_ev;
  pcs_flags_t  flags;
  logic [15:0] status_word;
  logic [31:0] rd_word;
  logic        perr_seen;
  logic        perr_own;
  logic        par_cause;
  logic        own_mabort;
  logic        own_tabort;
  logic        tgt_abort;
  logic        mpar_cause;
  logic        perr_cause;
  logic        serr_addr_cause;
  logic        serr_other_cause;

  // ----------------------------------------------------------------------
  // event qualification
  // ----------------------------------------------------------------------
  // the pin input is read only after the second stage
  assign perr_seen = ~st.perr_sync;
  // own drive counts at once, not only through the slower pin echo
  assign perr_own  = st.perr_drive;

  // any parity error is recorded, whatever the response enable says
  assign par_cause = addr_parity_err_i | data_parity_err_i;
  // a special cycle has no target, so its abort is normal, not an error
  assign own_mabort = master_active_i & master_abort_i
                      & ~special_cycle_i;
  assign own_tabort = master_active_i & target_abort_rcv_i;
  assign tgt_abort  = ~master_active_i & target_abort_sig_i;
  assign mpar_cause = (perr_own | perr_seen) & master_active_i
                      & parity_response_enable_i;
  assign perr_cause = data_parity_err_i
                      & parity_response_enable_i;
  assign serr_addr_cause  = addr_parity_err_i & system_error_enable_i
                            & parity_response_enable_i;
  assign serr_other_cause = sys_err_req_i & system_error_enable_i;

  always_comb begin
    set_ev                    = '0;
    set_ev[PCS_EV_PARITY]     = par_cause;
    set_ev[PCS_EV_SYSERR]     = st.serr_drive;
    set_ev[PCS_EV_MABORT]     = own_mabort;
    set_ev[PCS_EV_TABORT_IN]  = own_tabort;
    set_ev[PCS_EV_TABORT_OUT] = tgt_abort;
    set_ev[PCS_EV_MPARITY]    = mpar_cause;
  end

  // ----------------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------------
  // no clear path exists; only reset empties them
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_flag
      pcs_flag u_flag (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (set_ev[gi]),
        .flag_o (flags[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------------
  // status word assembly
  // ----------------------------------------------------------------------
  always_comb begin
    status_word                  = '0;
    status_word[`PCS_PARITY_BIT]     = flags[PCS_EV_PARITY];
    status_word[`PCS_SYSERR_BIT]     = flags[PCS_EV_SYSERR];
    status_word[`PCS_MABORT_BIT]     = flags[PCS_EV_MABORT];
    status_word[`PCS_TABORT_IN_BIT]  = flags[PCS_EV_TABORT_IN];
    status_word[`PCS_TABORT_OUT_BIT] = flags[PCS_EV_TABORT_OUT];
    // fixed medium decode, config cycles excluded from this figure
    status_word[`PCS_TIMING_HI:`PCS_TIMING_LO] = PCS_TIMING_MEDIUM;
    status_word[`PCS_MPARITY_BIT]    = flags[PCS_EV_MPARITY];
    status_word[`PCS_FBB_BIT]    = `PCS_FBB_VAL;
    status_word[6]               = `PCS_RSVD_VAL;
    status_word[`PCS_HS_BIT]     = `PCS_HS_VAL;
    status_word[`PCS_CAP_BIT]    = `PCS_CAP_VAL;
  end

  // ----------------------------------------------------------------------
  // read decode
  // ----------------------------------------------------------------------
  always_comb begin
    rd_word = `PCS_RDATA_RST;
    unique case ({cfg_addr_i, 2'b00})
      {`PCS_STATUS_OFS & 8'hFC}: begin
        rd_word[31:16] = status_word;
      end
      `PCS_REVID_OFS: begin
        rd_word[7:0] = REV_ID;
      end
      default: begin
        rd_word = `PCS_RDATA_RST;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_st            = st;
    next_st.perr_meta  = perr_n_i;
    next_st.perr_sync  = st.perr_meta;
    next_st.perr_drive = perr_cause;
    next_st.perr_n     = ~perr_cause;
    next_st.serr_drive = serr_addr_cause | serr_other_cause;
    next_st.serr_n     = ~(serr_addr_cause | serr_other_cause);
    next_st.rvalid     = cfg_rd_i;
    // writes are ignored: the word has no writable or clearable bit
    next_st.rdata      = cfg_rd_i ? rd_word : `PCS_RDATA_RST;
  end

  // ----------------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.rdata      <= `PCS_RDATA_RST;
      st.rvalid     <= 1'b0;
      st.perr_drive <= 1'b0;
      st.perr_n     <= 1'b1;
      st.serr_drive <= 1'b0;
      st.serr_n     <= 1'b1;
      // sync stages start at the idle high level: no false error at release
      st.perr_meta  <= 1'b1;
      st.perr_sync  <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign cfg_rdata_o  = st.rdata;
  assign cfg_rvalid_o = st.rvalid;
  assign perr_n_o     = st.perr_n;
  assign perr_oe_o    = st.perr_drive;
  assign serr_n_o     = st.serr_n;
  assign serr_oe_o    = st.serr_drive;

endmodule : pcs_status
`default_nettype wire

// ===== hdl/pcs_cfg.svh
// offsets, field positions and reset values of the bus event status block
`ifndef PCS_CFG_SVH
`define PCS_CFG_SVH

// ----------------------------------------------------------------------
// configuration space byte offsets
// ----------------------------------------------------------------------
`define PCS_STATUS_OFS      8'h06
`define PCS_REVID_OFS       8'h08

// ----------------------------------------------------------------------
// status word field positions
// ----------------------------------------------------------------------
`define PCS_PARITY_BIT      15
`define PCS_SYSERR_BIT      14
`define PCS_MABORT_BIT      13
`define PCS_TABORT_IN_BIT   12
`define PCS_TABORT_OUT_BIT  11
`define PCS_TIMING_HI       10
`define PCS_TIMING_LO       9
`define PCS_MPARITY_BIT     8
`define PCS_FBB_BIT         7
`define PCS_HS_BIT          5
`define PCS_CAP_BIT         4

// ----------------------------------------------------------------------
// fixed and reset values
// ----------------------------------------------------------------------
`define PCS_FLAG_RST        1'b0
`define PCS_FBB_VAL         1'b0
`define PCS_HS_VAL          1'b0
`define PCS_CAP_VAL         1'b1
`define PCS_RSVD_VAL        1'b0
`define PCS_RDATA_RST       32'h0000_0000
`define PCS_REVID_DEF       8'h5A

`endif

// ===== hdl/pcs_pkg.sv
// types shared by the bus event status block
package pcs_pkg;

  // ----------------------------------------------------------------------
  // target select timing encoding
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PCS_TIMING_FAST   = 2'h0,
    PCS_TIMING_MEDIUM = 2'h1,
    PCS_TIMING_SLOW   = 2'h2,
    PCS_TIMING_RSVD   = 2'h3
  } pcs_timing_e;

  // ----------------------------------------------------------------------
  // event flag indices into the flag vector
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PCS_EV_PARITY,
    PCS_EV_SYSERR,
    PCS_EV_MABORT,
    PCS_EV_TABORT_IN,
    PCS_EV_TABORT_OUT,
    PCS_EV_MPARITY
  } pcs_event_e;

  typedef logic [5:0] pcs_flags_t;

endpackage : pcs_pkg

// ===== hdl/pcs_flag.sv
// one sticky event flag, cleared only by reset
`timescale 1ns/1ps
`default_nettype none
`include "pcs_cfg.svh"

module pcs_flag
  import pcs_pkg::*;
(
  input  wire logic clk_i,   // bus clock
  input  wire logic rst_i,   // async reset, active high
  input  wire logic set_i,   // event pulse
  output logic      flag_o   // sticky flag
);

  typedef struct packed {
    logic flag;
  } pcs_flag_s;

  pcs_flag_s st;
  pcs_flag_s next_st;

  always_comb begin
    next_st      = st;
    next_st.flag = st.flag | set_i;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st.flag <= `PCS_FLAG_RST;
    end else begin
      st <= next_st;
    end
  end

  assign flag_o = st.flag;

endmodule : pcs_flag
`default_nettype wire

// ===== tb/pcs_bus_agent.sv
// far side model: another agent sharing the parity error line
`timescale 1ns/1ps
`default_nettype none
module pcs_bus_agent (
  input  wire logic       clk_i,      // bus clock
  input  wire logic       rst_i,      // async reset, active high
  input  wire logic       pull_i,     // request one cycle of error signalling
  input  wire logic [1:0] lag_i,      // response delay, 1 to 3 cycles
  input  wire logic       perr_n_i,   // device drive value
  input  wire logic       perr_oe_i,  // device output enable
  output logic            perr_lvl_o  // resolved line level
);
  logic [2:0] sh;
  // pulled up: the line reads high as soon as every driver lets go
  assign perr_lvl_o = ~((perr_oe_i & ~perr_n_i) | sh[lag_i]);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sh <= 3'h0;
    end else begin
      sh <= {sh[1:0], pull_i};
    end
  end
endmodule : pcs_bus_agent
`default_nettype wire

// ===== tb/pcs_status_assertions.sv
// port checker of the bus event status block
`timescale 1ns/1ps
`default_nettype none
module pcs_status_assertions #(
  parameter logic [7:0] REV_ID = 8'h00
) (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cfg_rd_i,
  input wire logic [7:2]  cfg_addr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic        cfg_rvalid_o,
  input wire logic        parity_response_enable_i,
  input wire logic        system_error_enable_i,
  input wire logic        addr_parity_err_i,
  input wire logic        data_parity_err_i,
  input wire logic        sys_err_req_i,
  input wire logic        perr_n_o,
  input wire logic        perr_oe_o,
  input wire logic        serr_n_o,
  input wire logic        serr_oe_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_stat_rd;
    cfg_rd_i && cfg_addr_i == 6'h01;
  endsequence
  sequence s_serr_rd;
    serr_oe_o ##[2:12] s_stat_rd;
  endsequence
  sequence s_par_rd;
    (addr_parity_err_i || data_parity_err_i) ##[2:12] s_stat_rd;
  endsequence
  a_rvalid_pulse: assert property (cfg_rd_i |=> cfg_rvalid_o)
    else $error("read not answered");
  a_idle_zero: assert property (!cfg_rd_i |=> !cfg_rvalid_o
    && cfg_rdata_o == 32'h0) else $error("idle read bus not zero");
  a_rev_read: assert property (cfg_rd_i && cfg_addr_i == 6'h02
    |=> cfg_rdata_o == {24'h0, REV_ID}) else $error("revision wrong");
  a_fixed_bits: assert property (s_stat_rd
    |=> cfg_rdata_o[26:25] == 2'h1 && cfg_rdata_o[23:0] == 24'h100000)
    else $error("fixed status bits wrong");
  a_perr_cause: assert property ($rose(perr_oe_o)
    |-> $past(data_parity_err_i && parity_response_enable_i))
    else $error("parity pin driven without cause");
  a_serr_drive: assert property (system_error_enable_i
    && (sys_err_req_i || addr_parity_err_i && parity_response_enable_i)
    |=> serr_oe_o && !serr_n_o) else $error("system error not driven");
  a_sse_flag: assert property (s_serr_rd |=> cfg_rdata_o[30])
    else $error("system error flag missing");
  a_dpe_flag: assert property (s_par_rd |=> cfg_rdata_o[31])
    else $error("parity flag missing");
endmodule : pcs_status_assertions
bind pcs_status pcs_status_assertions #(.REV_ID(REV_ID)) u_chk (
  .clk_i, .rst_i, .cfg_rd_i, .cfg_addr_i, .cfg_rdata_o, .cfg_rvalid_o,
  .parity_response_enable_i, .system_error_enable_i, .addr_parity_err_i,
  .data_parity_err_i, .sys_err_req_i, .perr_n_o, .perr_oe_o, .serr_n_o,
  .serr_oe_o);
`default_nettype wire

// ===== tb/pci_config_status_tb.sv
// self-checking bench of the bus event status block
`timescale 1ns/1ps
`default_nettype none
module pci_config_status_tb;
  localparam logic [7:0] REV = 8'hC3;  // arbitrary value
  logic        clk_i = 1'h0, rst_i = 1'h1, rd = '0, wr = '0, pen = '0;
  logic        se = '0, ap = '0, dp = '0, sy = '0, ma = '0, mab = '0;
  logic        sc = '0, tra = '0, tsa = '0, pull = '0, rd_d = '0;
  logic [1:0]  lag = '0;
  logic [3:0]  be = '0;
  logic [5:0]  ad = '0;
  logic [31:0] wd = '0, rdata, exp_d = '0;
  logic        rv, perr_n, po, serr_n, so, plvl;
  int          n_fail = 0, cmp_count = 0, st = 32'h0210;

  pcs_status #(.REV_ID(REV)) DUT (.clk_i, .rst_i, .cfg_rd_i(rd),
    .cfg_wr_i(wr), .cfg_addr_i(ad), .cfg_be_n_i(be), .cfg_wdata_i(wd),
    .cfg_rdata_o(rdata), .cfg_rvalid_o(rv), .parity_response_enable_i(pen),
    .system_error_enable_i(se), .addr_parity_err_i(ap),
    .data_parity_err_i(dp), .sys_err_req_i(sy), .master_active_i(ma),
    .master_abort_i(mab), .special_cycle_i(sc), .target_abort_rcv_i(tra),
    .target_abort_sig_i(tsa), .decode_timing_i(1'h0), .perr_n_i(plvl),
    .perr_n_o(perr_n), .perr_oe_o(po), .serr_n_o(serr_n), .serr_oe_o(so));
  pcs_bus_agent AG (.clk_i, .rst_i, .pull_i(pull), .lag_i(lag),
    .perr_n_i(perr_n), .perr_oe_i(po), .perr_lvl_o(plvl));

  initial forever #5 clk_i = ~clk_i;

  task automatic chk(input string n, input logic [31:0] e, s);
    cmp_count++;
    if (s !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic conclude;
    if (n_fail == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : conclude

  function automatic logic [31:0] rexp(input logic [5:0] a);
    if (a == 6'h01) return {st[15:0], 16'h0};
    if (a == 6'h02) return {24'h0, REV};
    return 32'h0;
  endfunction : rexp

  // every answer is judged against the read taken one edge earlier
  always @(posedge clk_i) begin
    #1;
    // a reset wipes the answer of a read taken at the same edge
    if (rst_i) begin
      rd_d = 1'h0;
      exp_d = 32'h0;
    end
    chk("rvalid", {31'h0, rd_d}, {31'h0, rv});
    chk("rdata", exp_d, rdata);
    rd_d = rd;
    exp_d = rd ? rexp(ad) : 32'h0;
  end

  // enables stay put for the whole episode so late pin echoes still qualify
  task automatic episode;
    logic [3:0] c;
    logic [7:0] p;
    logic       d, s;
    c = 4'($urandom);
    p = 8'($urandom & $urandom);
    @(posedge clk_i);
    {ma, sc, pen, se} <= c;
    @(posedge clk_i);
    {ap, dp, sy, mab, tra, tsa, pull, wr} <= p;
    lag <= 2'($urandom_range(2));
    wd <= $urandom;
    be <= 4'($urandom);
    ad <= 6'h01;
    d = p[6] & c[1];
    s = c[0] & (p[7] & c[1] | p[5]);
    if (p[7] | p[6]) st |= 32'h8000;
    if (s) st |= 32'h4000;
    if (p[4] & c[3] & !c[2]) st |= 32'h2000;
    if (p[3] & c[3]) st |= 32'h1000;
    if (p[2] & !c[3]) st |= 32'h0800;
    if (c[3] & c[1] & (p[6] | p[1])) st |= 32'h0100;
    @(posedge clk_i);
    {ap, dp, sy, mab, tra, tsa, pull, wr} <= 8'h00;
    #1;
    chk("perr pin", {30'h0, d, ~d}, {30'h0, po, perr_n});
    chk("serr pin", {30'h0, s, ~s}, {30'h0, so, serr_n});
    repeat (8) @(posedge clk_i);
    rd <= 1'h1;
    @(posedge clk_i);
    ad <= 6'h02;
    @(posedge clk_i);
    ad <= 6'($urandom);
    @(posedge clk_i);
    rd <= 1'h0;
  endtask : episode

  initial begin
    void'($urandom(68130));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'h0;
    for (int i = 0; i < 60; i++) begin
      if (i % 10 == 9) begin
        rst_i <= 1'h1;
        @(posedge clk_i);
        rst_i <= 1'h0;
        st = 32'h0210;
      end
      episode();
    end
    conclude();
  end

  initial begin
    #50000;
    n_fail++;
    conclude();
  end
endmodule : pci_config_status_tb
`default_nettype wire
